// ==== hdl/gpio_pkg.sv ====
// Constants shared by the dual pin group block
package gpio_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_A_LEVELS = 4'h0;
  localparam logic [3:0] OFS_A_HOLD = 4'h1;
  localparam logic [3:0] OFS_A_DIR = 4'h2;
  localparam logic [3:0] OFS_B_LEVELS = 4'h3;
  localparam logic [3:0] OFS_B_HOLD = 4'h4;
  localparam logic [3:0] OFS_B_DIR = 4'h5;
  localparam logic [3:0] OFS_IRQ_MAIN = 4'h6;
  localparam logic [3:0] OFS_IRQ_SECOND = 4'h7;
  localparam logic [3:0] OFS_CONV_CFG = 4'h8;
  localparam logic [3:0] OFS_LCD_EN_1 = 4'h9;
  localparam logic [3:0] OFS_LCD_EN_2 = 4'ha;
  localparam logic [3:0] OFS_LCD_EN_3 = 4'hb;
  localparam logic [3:0] OFS_OSC_CFG = 4'hc;
  localparam int CHANGE_FLAG_BIT = 0;
  localparam int PULLUP_N_BIT = 7;
  localparam int CONV_UNIMPL_BIT = 6;
  localparam int OSC_PRIMARY_BIT = 0;
  localparam int OSC_EXTCLK_BIT = 1;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] HOLD_RST = 8'h00;
  localparam logic [7:0] CONV_CFG_RST = 8'h00;
  localparam logic [7:0] IRQ_SECOND_RST = 8'h80;
  localparam logic [7:0] IRQ_MAIN_RST = 8'h00;
  localparam logic [7:0] LCD_EN_RST = 8'h00;
  localparam logic [1:0] OSC_CFG_RST = 2'h0;
  localparam logic [3:0] ANALOG_PIN_SELECT_ALL_ANALOG = 4'h0;
  localparam logic [1:0] CYCLE_DIV_LAST = 2'h3;
  localparam logic [1:0] CLEAR_HOLDOFF = 2'h1;
  // Per-pin analog enable from the select code, channels 0..4
  function automatic logic [4:0] analog_mask(input logic [3:0] sel);
    logic [4:0] m;
    m = 5'h00;
    for (int i = 0; i < 5; i++) begin
      m[i] = (sel <= 4'(4'hb - i));
    end
    return m;
  endfunction
endpackage

// ==== hdl/dual_gpio_port.sv ====
// Two 8-bit pin groups with alternate functions and change detect
// Contract
// [RULE1] Group A output pin drives latch, analog ignored
// [RULE2] Group A input read off when analog
// [RULE3] Channels 0-4 analog after reset
// [RULE4] A4 Schmitt input, always feeds timer0
// [RULE5] LCD segments override A1, A4, A5
// [RULE6] Primary oscillator disables A6/A7 digital I/O
// [RULE7] External clock: A6 outputs cycle clock
// [RULE8] Disabled A6/A7 bits read unknown
// [RULE9] Shared active-low pull-up at bit 7
// [RULE10] Output pins lose their pull-up
// [RULE11] Pull-ups off after reset
// [RULE12] Only input pins B7-B4 compared
// [RULE13] Mismatch vs read snapshot sets flag
// [RULE14] Flag clearable one cycle after read
// [RULE15] Software reads, waits, then clears flag
// [RULE16] Change interrupt wakes from low power
// [RULE17] Avoid polling group B during detection
// [RULE18] LCD segments take over B5-B0
// [RULE19] Converter config bit 6 reads zero
// [RULE20] Level read gives pins, write hits latch
// [RULE21] Direction 1 input, 0 drives latch
// [RULE22] Internal oscillator makes A6/A7 digital
// [RULE23] Pin inputs pass two-stage synchroniser
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dual_gpio_port
  import gpio_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe_out,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe_out,
  output logic [7:0] pb_pullup_out,
  input wire logic lcd_drive_18_in,
  input wire logic lcd_drive_14_in,
  input wire logic lcd_drive_15_in,
  input wire logic [5:0] lcd_drive_b_in,
  output logic timer0_ext_input_out,
  output logic [4:0] analog_en_out,
  output logic change_irq_out,
  output logic wake_out
);
  logic [7:0] a_hold_q, a_dir_q, b_hold_q, b_dir_q;
  logic [7:0] conv_cfg_q, irq_main_q, irq_second_q;
  logic [7:0] lcd_en_1_q, lcd_en_2_q, lcd_en_3_q;
  logic [1:0] osc_cfg_q;
  logic [7:0] pa_meta_q, pa_sync_q, pb_meta_q, pb_sync_q;
  logic [3:0] snap_q;
  logic [1:0] div_q;
  logic cycle_clk_q;
  logic [1:0] holdoff_q;
  logic [7:0] rdata_q;
  logic [4:0] an_en;
  logic [7:0] a_seg_en, a_dig_ok, a_read, b_seg_en, b_read;
  logic [3:0] mismatch;
  logic primary_osc, ext_clk, b_access, b_read_acc, a_rd_osc, flag_clr;
  logic any_mismatch;

  assign primary_osc = osc_cfg_q[OSC_PRIMARY_BIT];
  assign ext_clk = primary_osc & osc_cfg_q[OSC_EXTCLK_BIT];
  assign an_en = analog_mask(conv_cfg_q[3:0]);
  assign analog_en_out = an_en;

  // Segment enables from the LCD enable registers
  assign a_seg_en = {2'b00, lcd_en_1_q[7], lcd_en_1_q[6], 2'b00,
                     lcd_en_2_q[2], 1'b0}; // RULE5
  assign b_seg_en = {2'b00, lcd_en_3_q[5], lcd_en_1_q[3],
                     lcd_en_1_q[2], lcd_en_1_q[1], lcd_en_1_q[0],
                     lcd_en_3_q[6]}; // RULE18
  assign a_dig_ok = {{2{~primary_osc}}, ~a_seg_en[5:0]}; // RULE6 RULE22

  // Synchroniser: the first stage is read only by the second
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pa_meta_q <= 8'h00;
      pa_sync_q <= 8'h00;
      pb_meta_q <= 8'h00;
      pb_sync_q <= 8'h00;
    end else begin
      pa_meta_q <= pa_in; // RULE23
      pa_sync_q <= pa_meta_q;
      pb_meta_q <= pb_in;
      pb_sync_q <= pb_meta_q;
    end
  end

  // Cycle clock is a quarter of the system clock
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q <= 2'h0;
      cycle_clk_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      cycle_clk_q <= div_q[1]; // RULE7
    end
  end

  // Pin drivers
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pins
      always_comb begin
        if (a_seg_en[g]) begin
          pa_oe_out[g] = 1'b1; // RULE5
          pa_out[g] = (g == 1) ? lcd_drive_18_in :
                      (g == 4) ? lcd_drive_14_in : lcd_drive_15_in;
        end else if (g == 6 && ext_clk) begin
          pa_oe_out[g] = 1'b1; // RULE7
          pa_out[g] = cycle_clk_q;
        end else if (!a_dig_ok[g]) begin
          pa_oe_out[g] = 1'b0; // RULE6
          pa_out[g] = 1'b0;
        end else begin
          pa_oe_out[g] = ~a_dir_q[g]; // RULE1 RULE21
          pa_out[g] = a_hold_q[g];
        end
        if (g < 6 && b_seg_en[g]) begin
          pb_oe_out[g] = 1'b1; // RULE18
          pb_out[g] = lcd_drive_b_in[(g < 6) ? g : 0];
          pb_pullup_out[g] = 1'b0;
        end else begin
          pb_oe_out[g] = ~b_dir_q[g]; // RULE21
          pb_out[g] = b_hold_q[g];
          pb_pullup_out[g] = ~irq_second_q[PULLUP_N_BIT]
                             & b_dir_q[g]; // RULE9 RULE10
        end
      end
    end
  endgenerate

  // Timer0 sees A4 whatever its direction
  assign timer0_ext_input_out = pa_sync_q[4]; // RULE4

  // Digital read paths
  always_comb begin
    a_read = pa_sync_q;
    for (int i = 0; i < 5; i++) begin
      if (an_en[i]) begin
        a_read[(i == 4) ? 5 : i] = 1'b0; // RULE2
      end
    end
    b_read = pb_sync_q;
  end

  assign b_access = (wr_in | rd_in) &
                    ((addr_in == OFS_B_LEVELS) | (addr_in == OFS_B_HOLD));
  assign b_read_acc = b_access;
  assign a_rd_osc = primary_osc;

  // Change detection on input pins 7..4 only
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      mismatch[i] = b_dir_q[i+4] & ~b_seg_en[i+4]
                    & (pb_sync_q[i+4] != snap_q[i]); // RULE12
    end
  end
  assign any_mismatch = |mismatch; // RULE13

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      snap_q <= 4'h0;
    end else if (b_read_acc) begin
      snap_q <= pb_sync_q[7:4]; // RULE13
    end
  end

  // Clear is held off one cycle after a group B access
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      holdoff_q <= 2'h0;
    end else if (b_read_acc) begin
      holdoff_q <= CLEAR_HOLDOFF; // RULE14
    end else if (holdoff_q != 2'h0) begin
      holdoff_q <= holdoff_q - 2'h1;
    end
  end

  assign flag_clr = wr_in & (addr_in == OFS_IRQ_MAIN)
                    & ~wdata_in[CHANGE_FLAG_BIT];

  // Registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      a_hold_q <= HOLD_RST;
      a_dir_q <= DIR_RST;
      b_hold_q <= HOLD_RST;
      b_dir_q <= DIR_RST;
      conv_cfg_q <= CONV_CFG_RST; // RULE3
      irq_second_q <= IRQ_SECOND_RST; // RULE11
      lcd_en_1_q <= LCD_EN_RST;
      lcd_en_2_q <= LCD_EN_RST;
      lcd_en_3_q <= LCD_EN_RST;
      osc_cfg_q <= OSC_CFG_RST;
    end else if (wr_in) begin
      unique case (addr_in)
        OFS_A_LEVELS, OFS_A_HOLD: a_hold_q <= wdata_in; // RULE20
        OFS_A_DIR: a_dir_q <= wdata_in;
        OFS_B_LEVELS, OFS_B_HOLD: b_hold_q <= wdata_in; // RULE20
        OFS_B_DIR: b_dir_q <= wdata_in;
        OFS_CONV_CFG: begin
          conv_cfg_q <= wdata_in;
          conv_cfg_q[CONV_UNIMPL_BIT] <= 1'b0; // RULE19
        end
        OFS_IRQ_SECOND: irq_second_q <= wdata_in;
        OFS_LCD_EN_1: lcd_en_1_q <= wdata_in;
        OFS_LCD_EN_2: lcd_en_2_q <= wdata_in;
        OFS_LCD_EN_3: lcd_en_3_q <= wdata_in;
        OFS_OSC_CFG: osc_cfg_q <= wdata_in[1:0];
        default: ;
      endcase
    end
  end

  // Flag: set wins over clear; clear ignored during hold-off
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_main_q <= IRQ_MAIN_RST;
    end else begin
      if (wr_in && addr_in == OFS_IRQ_MAIN) begin
        irq_main_q[7:1] <= wdata_in[7:1];
      end
      if (any_mismatch) begin
        irq_main_q[CHANGE_FLAG_BIT] <= 1'b1; // RULE14
      end else if (flag_clr && holdoff_q == 2'h0) begin
        irq_main_q[CHANGE_FLAG_BIT] <= 1'b0;
      end else if (wr_in && addr_in == OFS_IRQ_MAIN
                   && wdata_in[CHANGE_FLAG_BIT]) begin
        // A write of 1 sets the flag; a refused clear matches no branch and the flag holds
        irq_main_q[CHANGE_FLAG_BIT] <= 1'b1;
      end
    end
  end

  assign change_irq_out = irq_main_q[CHANGE_FLAG_BIT];
  // Level output: the flag is set only on mclk_in edges, so no change is seen while the system clock is stopped in sleep
  assign wake_out = irq_main_q[CHANGE_FLAG_BIT]; // RULE16

  // Read data, one cycle after the strobe; A6/A7 read as x when off
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        OFS_A_LEVELS: rdata_q <= a_rd_osc ? {2'bxx, a_read[5:0]}
                                          : a_read; // RULE8 RULE20
        OFS_A_HOLD: rdata_q <= a_rd_osc ? {2'bxx, a_hold_q[5:0]}
                                        : a_hold_q; // RULE8
        OFS_A_DIR: rdata_q <= a_rd_osc ? {2'bxx, a_dir_q[5:0]}
                                       : a_dir_q; // RULE8
        OFS_B_LEVELS: rdata_q <= b_read; // RULE20
        OFS_B_HOLD: rdata_q <= b_hold_q;
        OFS_B_DIR: rdata_q <= b_dir_q;
        OFS_IRQ_MAIN: rdata_q <= irq_main_q;
        OFS_IRQ_SECOND: rdata_q <= irq_second_q;
        OFS_CONV_CFG: rdata_q <= conv_cfg_q & 8'hbf; // RULE19
        OFS_LCD_EN_1: rdata_q <= lcd_en_1_q;
        OFS_LCD_EN_2: rdata_q <= lcd_en_2_q;
        OFS_LCD_EN_3: rdata_q <= lcd_en_3_q;
        OFS_OSC_CFG: rdata_q <= {6'h00, osc_cfg_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign rdata_out = rdata_q;

  // Checks sit here so one glance covers every rule except RULE8, RULE15 and RULE17
  chk_output_drives_latch: assert property (@(posedge mclk_in) // RULE1
    disable iff (!rst_n_in)
    (!a_dir_q[0] && !a_seg_en[0])
      |-> (pa_oe_out[0] && pa_out[0] == a_hold_q[0]))
    else $error("A0 output not from latch");
  chk_analog_read_zero: assert property (@(posedge mclk_in) // RULE2
    disable iff (!rst_n_in)
    (rd_in && addr_in == OFS_A_LEVELS && an_en[0]) |=> !rdata_out[0])
    else $error("analog pin read not zero");
  chk_analog_high_zero: assert property (@(posedge mclk_in) // RULE2
    disable iff (!rst_n_in)
    (rd_in && addr_in == OFS_A_LEVELS && an_en[4]) |=> !rdata_out[5])
    else $error("channel 4 pin read not zero");
  chk_reset_defaults: assert property (@(posedge mclk_in) // RULE3
    disable iff (!rst_n_in)
    !$past(rst_n_in) |-> (&an_en))
    else $error("analog channels not default after reset");
  chk_sync_timer0: assert property (@(posedge mclk_in) // RULE4 RULE23
    disable iff (!rst_n_in)
    $past(rst_n_in, 2) |-> (pa_sync_q == $past(pa_in, 2)
      && pb_sync_q == $past(pb_in, 2)
      && timer0_ext_input_out == pa_sync_q[4]))
    else $error("pin synchroniser or timer0 input wrong");
  chk_seg_override: assert property (@(posedge mclk_in) // RULE5
    disable iff (!rst_n_in)
    a_seg_en[4] |-> (pa_oe_out[4] && pa_out[4] == lcd_drive_14_in))
    else $error("segment 14 not driven");
  chk_osc_pins_off: assert property (@(posedge mclk_in) // RULE6
    disable iff (!rst_n_in)
    (primary_osc && !ext_clk) |-> (pa_oe_out[7:6] == 2'b00))
    else $error("oscillator pins driven");
  chk_cycle_clock_pin: assert property (@(posedge mclk_in) // RULE7
    disable iff (!rst_n_in)
    ext_clk |-> (pa_oe_out[6] && pa_out[6] == cycle_clk_q))
    else $error("cycle clock not on A6");
  chk_cycle_clock_rate: assert property (@(posedge mclk_in) // RULE7
    disable iff (!rst_n_in)
    $changed(cycle_clk_q)
      |=> ($stable(cycle_clk_q) ##1 $changed(cycle_clk_q)))
    else $error("cycle clock not a quarter rate");
  chk_pullup_shared: assert property (@(posedge mclk_in) // RULE9
    disable iff (!rst_n_in)
    (!irq_second_q[PULLUP_N_BIT] && b_dir_q[7]) |-> pb_pullup_out[7])
    else $error("shared pull-up not applied");
  chk_pullup_output_off: assert property (@(posedge mclk_in) // RULE10
    disable iff (!rst_n_in)
    (!b_dir_q[4]) |-> !pb_pullup_out[4])
    else $error("pull-up on output pin");
  chk_pullup_ctl_off: assert property (@(posedge mclk_in) // RULE11
    disable iff (!rst_n_in)
    irq_second_q[PULLUP_N_BIT] |-> (pb_pullup_out == 8'h00))
    else $error("pull-up on while disabled");
  chk_output_excluded: assert property (@(posedge mclk_in) // RULE12
    disable iff (!rst_n_in)
    (!b_dir_q[4]) |-> !mismatch[0])
    else $error("output pin in change compare");
  chk_change_sets_flag: assert property (@(posedge mclk_in) // RULE13
    disable iff (!rst_n_in)
    any_mismatch |=> change_irq_out)
    else $error("mismatch did not set flag");
  chk_holdoff_clear: assert property (@(posedge mclk_in) // RULE14
    disable iff (!rst_n_in)
    b_read_acc ##1 (change_irq_out && flag_clr)
      |=> change_irq_out)
    else $error("flag cleared too early");
  chk_flag_sticky: assert property (@(posedge mclk_in) // RULE14
    disable iff (!rst_n_in)
    (change_irq_out && !flag_clr) |=> change_irq_out)
    else $error("flag dropped without a clear");
  chk_wake_level: assert property (@(posedge mclk_in) // RULE16
    disable iff (!rst_n_in)
    change_irq_out |-> wake_out)
    else $error("flag set but no wake");
  chk_b_seg_override: assert property (@(posedge mclk_in) // RULE18
    disable iff (!rst_n_in)
    b_seg_en[0] |-> (pb_oe_out[0] && !pb_pullup_out[0]
      && pb_out[0] == lcd_drive_b_in[0]))
    else $error("B0 segment not driven");
  chk_conv_bit6_zero: assert property (@(posedge mclk_in) // RULE19
    disable iff (!rst_n_in)
    (rd_in && addr_in == OFS_CONV_CFG) |=> !rdata_out[6])
    else $error("unimplemented bit not zero");
  chk_level_write_latch: assert property (@(posedge mclk_in) // RULE20
    disable iff (!rst_n_in)
    (wr_in && addr_in == OFS_A_LEVELS) |=> (a_hold_q == $past(wdata_in)))
    else $error("level write missed the latch");
  chk_read_one_cycle: assert property (@(posedge mclk_in) // RULE20
    disable iff (!rst_n_in)
    (!rd_in) |=> (rdata_out == 8'h00))
    else $error("read data outside slot");
  chk_input_no_drive: assert property (@(posedge mclk_in) // RULE21
    disable iff (!rst_n_in)
    (a_dir_q[2] && b_dir_q[2] && !b_seg_en[2])
      |-> !(pa_oe_out[2] || pb_oe_out[2]))
    else $error("input pin driven");
  chk_internal_osc_pins: assert property (@(posedge mclk_in) // RULE22
    disable iff (!rst_n_in)
    !primary_osc |-> (pa_oe_out[7:6] == ~a_dir_q[7:6]))
    else $error("A6/A7 not plain pins");
endmodule
`default_nettype wire

// ==== verif/pin_board.sv ====
// Board model: external drivers, floating lines and weak pull-ups
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input wire logic clk_in,
  input wire logic [7:0] a_drv_in,
  input wire logic [7:0] a_oe_in,
  input wire logic [7:0] b_drv_in,
  input wire logic [7:0] b_oe_in,
  input wire logic [7:0] b_pu_in,
  input wire logic [7:0] a_ext_in,
  input wire logic [7:0] a_ext_en_in,
  input wire logic [7:0] b_ext_in,
  input wire logic [7:0] b_ext_en_in,
  output logic [7:0] a_pin_out,
  output logic [7:0] b_pin_out
);
  logic [7:0] a_last_q = 8'h00;
  logic [7:0] b_last_q = 8'h00;
  logic [7:0] a_free;
  logic [7:0] b_free;
  assign a_free = ~a_oe_in & ~a_ext_en_in;
  assign b_free = ~b_oe_in & ~b_ext_en_in;
  // Undriven lines flip each cycle unless pulled up, so a stale level never passes
  assign a_pin_out = (a_oe_in & a_drv_in) | (a_free & ~a_last_q)
    | (~a_oe_in & a_ext_en_in & a_ext_in);
  assign b_pin_out = (b_oe_in & b_drv_in) | (b_free & (b_pu_in | ~b_last_q))
    | (~b_oe_in & b_ext_en_in & b_ext_in);
  always_ff @(posedge clk_in) begin
    a_last_q <= a_pin_out;
    b_last_q <= b_pin_out;
  end
endmodule
`default_nettype wire

// ==== verif/tb_dual_gpio_port.sv ====
// Self-checking bench for the dual pin group block
`timescale 1ns/1ps
`default_nettype none
module tb_dual_gpio_port;
  import gpio_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic l18 = 1'b0;
  logic l14 = 1'b0;
  logic l15 = 1'b0;
  logic [5:0] lb = 6'h00;
  logic [7:0] a_ext = 8'h00;
  logic [7:0] a_en = 8'h00;
  logic [7:0] b_ext = 8'h00;
  logic [7:0] b_en = 8'h00;
  logic [7:0] rdata, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pb_pu;
  logic t0, irq, wake;
  logic [4:0] ana;
  logic [7:0] d;
  int fail_count = 0;
  int n_checks = 0;
  always #50 mclk_in = ~mclk_in;
  dual_gpio_port i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe_out(pa_oe),
    .pb_in(pb_in), .pb_out(pb_out), .pb_oe_out(pb_oe),
    .pb_pullup_out(pb_pu), .lcd_drive_18_in(l18), .lcd_drive_14_in(l14),
    .lcd_drive_15_in(l15), .lcd_drive_b_in(lb), .timer0_ext_input_out(t0),
    .analog_en_out(ana), .change_irq_out(irq), .wake_out(wake));
  pin_board i_board (.clk_in(mclk_in), .a_drv_in(pa_out), .a_oe_in(pa_oe),
    .b_drv_in(pb_out), .b_oe_in(pb_oe), .b_pu_in(pb_pu), .a_ext_in(a_ext),
    .a_ext_en_in(a_en), .b_ext_in(b_ext), .b_ext_en_in(b_en),
    .a_pin_out(pa_in), .b_pin_out(pb_in));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // Flag must rise within six cycles, twice the synchroniser plus compare latency
  task automatic wait_flag();
    for (int i = 0; i < 6; i++) begin
      tick(1);
      if (irq === 1'b1) return;
    end
    fail_count++;
    $display("[ERR] %0t change flag never rose", $time);
    tally_and_finish();
  endtask
  task automatic t_reset();
    cmp({3'h0, ana}, 8'h1f, "analog default");
    cmp(pa_oe | pb_oe, 8'h00, "no drive");
    cmp(pb_pu, 8'h00, "pull-ups");
    rd_reg(OFS_A_DIR, d);
    cmp(d, 8'hff, "dir a");
    rd_reg(OFS_IRQ_SECOND, d);
    cmp(d, 8'h80, "pull-up ctl");
  endtask
  task automatic t_a_out();
    wr_reg(OFS_A_DIR, 8'h00);
    wr_reg(OFS_A_LEVELS, 8'h3c);
    tick(3);
    cmp(pa_oe, 8'hff, "oe a");
    cmp(pa_out, 8'h3c, "drive a with analog on");
    cmp({7'h0, t0}, 8'h01, "timer0 from output pin");
    rd_reg(OFS_A_HOLD, d);
    cmp(d, 8'h3c, "level write hits latch");
  endtask
  task automatic t_a_in();
    a_ext <= 8'h5a;
    a_en <= 8'hff;
    wr_reg(OFS_A_DIR, 8'hff);
    tick(3);
    rd_reg(OFS_A_LEVELS, d);
    cmp(d, 8'h50, "analog pins read 0");
    wr_reg(OFS_CONV_CFG, 8'hff);
    rd_reg(OFS_CONV_CFG, d);
    cmp(d, 8'hbf, "cfg bit 6");
    cmp({3'h0, ana}, 8'h00, "analog off");
    rd_reg(OFS_A_LEVELS, d);
    cmp(d, 8'h5a, "digital read incl 7:6");
    a_en <= 8'h00;
  endtask
  task automatic t_lcd();
    l18 <= 1'b1;
    l15 <= 1'b1;
    lb <= 6'h2b;
    wr_reg(OFS_LCD_EN_2, 8'h04);
    wr_reg(OFS_LCD_EN_1, 8'hcf);
    wr_reg(OFS_LCD_EN_3, 8'h60);
    tick(1);
    cmp({5'h0, pa_out[5:4], pa_out[1]}, 8'h05, "seg a");
    cmp({5'h0, pa_oe[5:4], pa_oe[1]}, 8'h07, "seg a oe");
    cmp({2'h0, pb_out[5:0]}, 8'h2b, "seg b");
    cmp({2'h0, pb_oe[5:0]}, 8'h3f, "seg b oe");
    wr_reg(OFS_LCD_EN_1, 8'h00);
    wr_reg(OFS_LCD_EN_3, 8'h00);
  endtask
  task automatic t_osc();
    int n;
    logic p;
    n = 0;
    wr_reg(OFS_A_DIR, 8'h00);
    wr_reg(OFS_OSC_CFG, 8'h01);
    tick(1);
    cmp({6'h0, pa_oe[7:6]}, 8'h00, "osc pins no drive");
    rd_reg(OFS_A_LEVELS, d);
    cmp({d[7:6], 6'h0}, {2'bxx, 6'h0}, "osc pins read");
    wr_reg(OFS_OSC_CFG, 8'h03);
    tick(2);
    p = pa_out[6];
    for (int i = 0; i < 8; i++) begin
      tick(1);
      if (pa_out[6] !== p) n++;
      p = pa_out[6];
    end
    cmp(8'(n), 8'h04, "cycle clock rate");
    cmp({7'h0, pa_oe[6]}, 8'h01, "cycle clock oe");
    wr_reg(OFS_OSC_CFG, 8'h00);
  endtask
  task automatic t_change();
    b_ext <= 8'ha0;
    b_en <= 8'hf0;
    wr_reg(OFS_B_DIR, 8'hf0);
    tick(3);
    rd_reg(OFS_B_LEVELS, d);
    // Floating pins earlier in the run may have left the flag set
    wr_reg(OFS_IRQ_MAIN, 8'h00);
    tick(4);
    cmp({7'h0, irq}, 8'h00, "no change");
    b_ext <= 8'hb0;
    wait_flag();
    cmp({7'h0, wake}, 8'h01, "wake");
    wr_reg(OFS_IRQ_MAIN, 8'h00);
    tick(1);
    cmp({7'h0, irq}, 8'h01, "clear during mismatch");
    @(posedge mclk_in);
    addr <= OFS_B_LEVELS;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    addr <= OFS_IRQ_MAIN;
    wdata <= 8'h00;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
    tick(1);
    cmp({7'h0, irq}, 8'h01, "clear too early");
    wr_reg(OFS_IRQ_MAIN, 8'h00);
    tick(1);
    cmp({7'h0, irq}, 8'h00, "clear after wait");
    // Direction first, so pin 4 never floats while still an input
    wr_reg(OFS_B_DIR, 8'he0);
    b_en <= 8'he0;
    wr_reg(OFS_B_HOLD, 8'h1f);
    tick(5);
    cmp({7'h0, irq}, 8'h00, "outputs excluded");
    wr_reg(OFS_IRQ_SECOND, 8'h00);
    tick(1);
    cmp(pb_pu, 8'he0, "pull-ups inputs only");
  endtask
  initial begin
    repeat (6) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    tick(1);
    t_reset();
    t_a_out();
    t_a_in();
    t_lcd();
    t_osc();
    t_change();
    tally_and_finish();
  end
endmodule
`default_nettype wire
